/* File: src/ists_sequencer.v */
`include "ists_map.vh"

// Overview of operation
// - self-test runs through init phases two and three, done before normal data
// - phase one: stimulus off, average raw offset over interval one
// - offset cancellation frozen for interval two plus 2 ms
// - stimulus on, wait half interval two, average other half, stimulus off
// - self-test value outside upper or lower deflection limit is a failure
// - phase three: stimulus off, average offset over interval three for normal data
// - passing sequence ends self-test and enters normal mode, no more repeats
// - failed test reruns all three phases up to retry count, zero none
// - init phase three sends busy, then ready or defect frames only
// - phase three lasts frames until self-test done plus two more frames
// - 228 us mode: busy frames then two result frames; busy count from timing
// - failure after all retries latches defect frames until reset
// - offset out of limits sends defect only while it persists
// - either integrity flag cleared latches defect frames until reset
// - undervoltage stops all frames
// - undervoltage silence ends by itself when supply recovers
// - init phase two sends 512 frames before phase three
module ists_sequencer #(
  parameter [15:0] MS_CYCLES = `ISTS_MS_CYCLES,
  parameter [15:0] FRAME_CYCLES = `ISTS_FRAME_CYCLES,
  parameter [15:0] INIT_MS = 16'h000A,
  parameter [15:0] OC1_MS = 16'h0005,
  parameter [15:0] OC2_MS = 16'h0005,
  parameter [15:0] ST1_MS = 16'h0008,
  parameter [15:0] ST2_MS = 16'h0010,
  parameter [15:0] ST3_MS = 16'h0008,
  parameter [9:0] INIT1_FRAMES = 10'h004
) (
  input wire ref_clk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire sample_valid,
  input wire [15:0] accel_sample,
  input wire uv_trip_pin,
  input wire integrity_flag_a,
  input wire integrity_flag_b,
  output wire selftest_stim_en,
  output wire offset_hold,
  output reg [15:0] offset_est_q,
  output reg frame_strobe_q,
  output reg [2:0] msg_kind_q,
  output wire normal_mode,
  output wire irq
);

  localparam S_INIT = 3'h0;
  localparam S_ST1 = 3'h1;
  localparam S_ST2_ON = 3'h2;
  localparam S_ST2_AVG = 3'h3;
  localparam S_HOLD = 3'h4;
  localparam S_ST3 = 3'h5;
  localparam S_DONE = 3'h6;

  localparam PH1 = 2'h0;
  localparam PH2 = 2'h1;
  localparam PH3 = 2'h2;
  localparam PHN = 2'h3;

  localparam [15:0] HALF2_MS = {1'b0, ST2_MS[15:1]};
  localparam [15:0] EXTRA_MS = `ISTS_ST2_EXTRA_MS;
  localparam [15:0] PRE_MS = INIT_MS + OC1_MS + OC2_MS;

  reg [2:0] state_q;
  reg [15:0] ms_cnt_q;
  reg [15:0] timer_q;
  reg [2:0] retry_q;
  reg [2:0] tries_q;
  reg bad_q;
  reg done_q;
  reg pass_q;
  reg st_defect_q;
  reg integ_defect_q;
  reg offset_err_q;
  reg [15:0] st_value_q;
  reg [15:0] defl_hi_q;
  reg [15:0] defl_lo_q;
  reg [15:0] ofs_lim_q;
  reg [4:0] irq_stat_q;
  reg [4:0] irq_mask_q;
  reg uv_meta_q;
  reg uv_q;
  reg uv_prev_q;
  reg [15:0] frame_cnt_q;
  reg [1:0] phase_q;
  reg [9:0] frm_idx_q;
  reg [1:0] res_cnt_q;
  reg [15:0] rdata_d;

  wire ms_tick;
  wire timer_end;
  wire frame_tick;
  wire avg_run;
  wire avg_start;
  wire avg_full;
  wire [15:0] avg_mean;
  wire [15:0] defl;
  wire [15:0] mean_abs;
  wire defl_ok;
  wire last_try;
  wire pass_ev;
  wire fail_ev;
  wire defect_now;
  wire [4:0] irq_ev;
  wire [4:0] irq_clr;
  wire [15:0] status;

  // length of each sequence step in ms ticks
  function [15:0] step_len;
    input [2:0] s;
    begin
      case (s)
        S_INIT: step_len = PRE_MS;
        S_ST1: step_len = ST1_MS;
        S_ST2_ON: step_len = HALF2_MS;
        S_ST2_AVG: step_len = ST2_MS - HALF2_MS;
        S_HOLD: step_len = EXTRA_MS;
        S_ST3: step_len = ST3_MS;
        default: step_len = 16'h0001;
      endcase
    end
  endfunction

  // 1 ms enable from the system clock
  assign ms_tick = (ms_cnt_q == MS_CYCLES - 16'h0001);
  assign timer_end = ms_tick && (timer_q == step_len(state_q) - 16'h0001);
  assign frame_tick = (frame_cnt_q == FRAME_CYCLES - 16'h0001);

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ms_cnt_q <= 16'h0000;
    else if (ms_tick)
      ms_cnt_q <= 16'h0000;
    else
      ms_cnt_q <= ms_cnt_q + 16'h0001;
  end

  // averager runs in each measuring step and keeps running after the test
  // normal-mode windows restart the cycle after they fill, so none is skipped
  assign avg_run = (state_q == S_ST1) || (state_q == S_ST2_AVG) ||
                   (state_q == S_ST3) || (state_q == S_DONE);
  assign avg_start = (timer_end && ((state_q == S_INIT) || (state_q == S_ST2_ON) ||
                     (state_q == S_HOLD) || (state_q == S_ST3))) ||
                     (state_q == S_DONE && avg_full);

  ists_avg u_avg (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(avg_start),
    .run(avg_run),
    .sample_valid(sample_valid),
    .sample(accel_sample),
    .mean_q(avg_mean),
    .full_q(avg_full)
  );

  // stimulus on only through interval two, offset frozen two ms beyond it
  assign selftest_stim_en = (state_q == S_ST2_ON) || (state_q == S_ST2_AVG);
  assign offset_hold = selftest_stim_en || (state_q == S_HOLD);

  // deflection is measured against the phase-one offset estimate
  assign defl = avg_mean - offset_est_q;
  assign defl_ok = ($signed(defl) <= $signed(defl_hi_q)) &&
                   ($signed(defl) >= $signed(defl_lo_q));
  assign mean_abs = avg_mean[15] ? (16'h0000 - avg_mean) : avg_mean;
  assign last_try = (tries_q >= retry_q);
  assign pass_ev = (state_q == S_ST3) && timer_end && !bad_q && avg_full;
  assign fail_ev = (state_q == S_ST3) && timer_end && !(!bad_q && avg_full) && last_try;

  // self-test sequencer; a short averaging window counts as a failed step
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= S_INIT;
      timer_q <= 16'h0000;
      tries_q <= 3'h0;
      bad_q <= 1'b0;
      done_q <= 1'b0;
      pass_q <= 1'b0;
      st_defect_q <= 1'b0;
      st_value_q <= 16'h0000;
      offset_est_q <= 16'h0000;
    end
    else
    begin
      if (timer_end)
        timer_q <= 16'h0000;
      else if (ms_tick && state_q != S_DONE)
        timer_q <= timer_q + 16'h0001;
      case (state_q)
        S_INIT:
          if (timer_end)
            state_q <= S_ST1;
        S_ST1:
          if (timer_end)
          begin
            offset_est_q <= avg_mean;
            bad_q <= !avg_full;
            state_q <= S_ST2_ON;
          end
        S_ST2_ON:
          if (timer_end)
            state_q <= S_ST2_AVG;
        S_ST2_AVG:
          if (timer_end)
          begin
            st_value_q <= defl;
            bad_q <= bad_q || !avg_full || !defl_ok;
            state_q <= S_HOLD;
          end
        S_HOLD:
          if (timer_end)
            state_q <= S_ST3;
        S_ST3:
          if (timer_end)
          begin
            if (avg_full)
              offset_est_q <= avg_mean;
            if (!bad_q && avg_full)
            begin
              pass_q <= 1'b1;
              done_q <= 1'b1;
              state_q <= S_DONE;
            end
            else if (!last_try)
            begin
              tries_q <= tries_q + 3'h1;
              bad_q <= 1'b0;
              state_q <= S_ST1;
            end
            else
            begin
              st_defect_q <= 1'b1;
              done_q <= 1'b1;
              state_q <= S_DONE;
            end
          end
        S_DONE:
          if (avg_full && phase_q == PHN)
            offset_est_q <= avg_mean;
        default:
          state_q <= S_INIT;
      endcase
    end
  end

  // offset error follows each fresh normal-mode window, so it clears itself
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      offset_err_q <= 1'b0;
    else if (state_q == S_DONE && phase_q == PHN && avg_full)
      offset_err_q <= (mean_abs > ofs_lim_q);
  end

  // integrity flags are active high when healthy; any clear latches a defect
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      integ_defect_q <= 1'b0;
    else if (!integrity_flag_a || !integrity_flag_b)
      integ_defect_q <= 1'b1;
  end

  // undervoltage pin is asynchronous; two flops before any use
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      uv_meta_q <= 1'b0;
      uv_q <= 1'b0;
      uv_prev_q <= 1'b0;
    end
    else
    begin
      uv_meta_q <= uv_trip_pin;
      uv_q <= uv_meta_q;
      uv_prev_q <= uv_q;
    end
  end

  // frame period enable
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      frame_cnt_q <= 16'h0000;
    else if (frame_tick)
      frame_cnt_q <= 16'h0000;
    else
      frame_cnt_q <= frame_cnt_q + 16'h0001;
  end

  assign defect_now = st_defect_q || integ_defect_q;

  // init phase tracking and message choice; phases count only sent frames
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_q <= PH1;
      frm_idx_q <= 10'h000;
      res_cnt_q <= 2'h0;
      frame_strobe_q <= 1'b0;
      msg_kind_q <= `ISTS_MSG_NONE;
    end
    else
    begin
      frame_strobe_q <= frame_tick && !uv_q;
      if (frame_tick && uv_q)
        msg_kind_q <= `ISTS_MSG_NONE;
      else if (frame_tick)
      begin
        case (phase_q)
          PH1:
          begin
            msg_kind_q <= `ISTS_MSG_INIT1;
            frm_idx_q <= frm_idx_q + 10'h001;
            if (frm_idx_q == INIT1_FRAMES - 10'h001)
            begin
              frm_idx_q <= 10'h000;
              phase_q <= PH2;
            end
          end
          PH2:
          begin
            msg_kind_q <= `ISTS_MSG_INIT2;
            frm_idx_q <= frm_idx_q + 10'h001;
            if (frm_idx_q == `ISTS_INIT2_FRAMES - 10'h001)
            begin
              frm_idx_q <= 10'h000;
              phase_q <= PH3;
            end
          end
          PH3:
            if (!done_q)
              msg_kind_q <= `ISTS_MSG_BUSY;
            else
            begin
              msg_kind_q <= defect_now ? `ISTS_MSG_DEFECT : `ISTS_MSG_READY;
              res_cnt_q <= res_cnt_q + 2'h1;
              if (res_cnt_q == `ISTS_RESULT_FRAMES - 2'h1)
                phase_q <= PHN;
            end
          default:
            msg_kind_q <= (defect_now || offset_err_q) ?
                          `ISTS_MSG_DEFECT : `ISTS_MSG_DATA;
        endcase
      end
    end
  end

  assign normal_mode = (phase_q == PHN);

  // sticky events; a set in the clearing cycle wins
  assign irq_ev[`ISTS_IRQ_PASS] = pass_ev;
  assign irq_ev[`ISTS_IRQ_FAIL] = fail_ev;
  assign irq_ev[`ISTS_IRQ_OFS] = (state_q == S_DONE) && (phase_q == PHN) && avg_full &&
                                 (mean_abs > ofs_lim_q) && !offset_err_q;
  assign irq_ev[`ISTS_IRQ_UV] = uv_q && !uv_prev_q;
  assign irq_ev[`ISTS_IRQ_INTEG] = (!integrity_flag_a || !integrity_flag_b) && !integ_defect_q;
  assign irq_clr = (reg_wr && reg_addr == `ISTS_REG_IRQ_STAT) ? reg_wdata[4:0] : 5'h00;
  assign irq = |(irq_stat_q & irq_mask_q);

  // software registers
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      retry_q <= `ISTS_RST_RETRY;
      defl_hi_q <= `ISTS_RST_DEFL_HI;
      defl_lo_q <= `ISTS_RST_DEFL_LO;
      ofs_lim_q <= `ISTS_RST_OFS_LIM;
      irq_mask_q <= `ISTS_RST_IRQ_MASK;
      irq_stat_q <= 5'h00;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
      if (reg_wr)
      begin
        case (reg_addr)
          `ISTS_REG_CTRL: retry_q <= reg_wdata[2:0];
          `ISTS_REG_DEFL_HI: defl_hi_q <= reg_wdata;
          `ISTS_REG_DEFL_LO: defl_lo_q <= reg_wdata;
          `ISTS_REG_OFS_LIM: ofs_lim_q <= reg_wdata;
          `ISTS_REG_IRQ_MASK: irq_mask_q <= reg_wdata[4:0];
          default: ;
        endcase
      end
    end
  end

  assign status = {2'h0, tries_q, phase_q, uv_q, offset_err_q, integ_defect_q,
                   st_defect_q, pass_q, done_q, state_q};

  // read mux; unmapped addresses read zero
  always @*
  begin
    case (reg_addr)
      `ISTS_REG_CTRL: rdata_d = {13'h0000, retry_q};
      `ISTS_REG_DEFL_HI: rdata_d = defl_hi_q;
      `ISTS_REG_DEFL_LO: rdata_d = defl_lo_q;
      `ISTS_REG_OFS_LIM: rdata_d = ofs_lim_q;
      `ISTS_REG_STATUS: rdata_d = status;
      `ISTS_REG_IRQ_STAT: rdata_d = {11'h000, irq_stat_q};
      `ISTS_REG_IRQ_MASK: rdata_d = {11'h000, irq_mask_q};
      `ISTS_REG_OFFSET: rdata_d = offset_est_q;
      `ISTS_REG_ST_VALUE: rdata_d = st_value_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 16'h0000;
  end

endmodule // ists_sequencer

/* File: inc/ists_map.vh */
`ifndef ISTS_MAP_VH
`define ISTS_MAP_VH

// clock and time bases
`define ISTS_CLK_KHZ 50000
`define ISTS_MS_TIME 1
// cycle counts sized to the 16-bit counters that use them
`define ISTS_MS_CYCLES 16'hC350
`define ISTS_FRAME_US 228
`define ISTS_FRAME_CYCLES 16'h2C88

// sequence timing
`define ISTS_ST2_EXTRA_MS 16'h0002
`define ISTS_INIT2_FRAMES 10'h200
`define ISTS_INIT2_REPEAT 8
`define ISTS_RESULT_FRAMES 2'h2

// averaging window is 2**log2 samples
`define ISTS_AVG_LOG2 4
`define ISTS_AVG_COUNT 5'h10

// register byte offsets
`define ISTS_REG_CTRL 8'h00
`define ISTS_REG_DEFL_HI 8'h04
`define ISTS_REG_DEFL_LO 8'h08
`define ISTS_REG_OFS_LIM 8'h0C
`define ISTS_REG_STATUS 8'h10
`define ISTS_REG_IRQ_STAT 8'h14
`define ISTS_REG_IRQ_MASK 8'h18
`define ISTS_REG_OFFSET 8'h1C
`define ISTS_REG_ST_VALUE 8'h20

// reset values
`define ISTS_RST_RETRY 3'h0
`define ISTS_RST_DEFL_HI 16'h0400
`define ISTS_RST_DEFL_LO 16'h0100
`define ISTS_RST_OFS_LIM 16'h0200
`define ISTS_RST_IRQ_MASK 5'h00

// irq bit positions
`define ISTS_IRQ_PASS 0
`define ISTS_IRQ_FAIL 1
`define ISTS_IRQ_OFS 2
`define ISTS_IRQ_UV 3
`define ISTS_IRQ_INTEG 4

// message kinds
`define ISTS_MSG_NONE 3'h0
`define ISTS_MSG_INIT1 3'h1
`define ISTS_MSG_INIT2 3'h2
`define ISTS_MSG_BUSY 3'h3
`define ISTS_MSG_READY 3'h4
`define ISTS_MSG_DEFECT 3'h5
`define ISTS_MSG_DATA 3'h6

`endif

/* File: src/ists_avg.v */
`include "ists_map.vh"

// fixed-length averager: sums the first 2**log2 samples after start
module ists_avg (
  input wire ref_clk,
  input wire resetn,
  input wire start,
  input wire run,
  input wire sample_valid,
  input wire [15:0] sample,
  output reg [15:0] mean_q,
  output reg full_q
);

  reg [19:0] sum_q;
  reg [4:0] cnt_q;
  wire [19:0] sum_next;
  wire take;

  // sign-extend so negative offsets average correctly
  assign sum_next = sum_q + {{4{sample[15]}}, sample};
  assign take = run && sample_valid && !full_q && !start;

  // accumulate; the mean is latched on the last sample so it stays stable
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sum_q <= 20'h00000;
      cnt_q <= 5'h00;
      full_q <= 1'b0;
      mean_q <= 16'h0000;
    end
    else if (start)
    begin
      sum_q <= 20'h00000;
      cnt_q <= 5'h00;
      full_q <= 1'b0;
    end
    else if (take)
    begin
      sum_q <= sum_next;
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q == `ISTS_AVG_COUNT - 5'h01)
      begin
        full_q <= 1'b1;
        mean_q <= sum_next[`ISTS_AVG_LOG2 +: 16];
      end
    end
  end

endmodule // ists_avg

/* File: test/ists_props.sv */
`include "ists_map.vh"

// watches the sequencer's pins for timing relations of the self-test and frame link
module ists_props #(
  parameter [15:0] MS_CYCLES = 16'h000A,
  parameter [15:0] FRAME_CYCLES = 16'h0014
) (
  input wire ref_clk,
  input wire resetn,
  input wire uv_trip_pin,
  input wire integrity_flag_a,
  input wire integrity_flag_b,
  input wire selftest_stim_en,
  input wire offset_hold,
  input wire [15:0] offset_est_q,
  input wire frame_strobe_q,
  input wire [2:0] msg_kind_q,
  input wire normal_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap_q;
  logic seen_q;
  logic bad_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // distance between strobes; silenced ticks leave whole periods out
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gap_q <= 0;
      seen_q <= 1'b0;
      bad_q <= 1'b0;
    end
    else
    begin
      gap_q <= frame_strobe_q ? 1 : gap_q + 1;
      seen_q <= seen_q | frame_strobe_q;
      bad_q <= bad_q | !integrity_flag_a | !integrity_flag_b;
    end
  end

  a_hold_covers_stim: assert property (selftest_stim_en |-> offset_hold)
    else $error("offset not held while stimulus on");
  a_hold_tail_after: assert property ($fell(selftest_stim_en) |-> offset_hold [*8])
    else $error("offset hold ended with the stimulus");
  a_offset_frozen: assert property (offset_hold && $past(offset_hold) |-> $stable(offset_est_q))
    else $error("offset estimate moved during hold");
  a_stim_min_len: assert property ($rose(selftest_stim_en) |-> selftest_stim_en [*8])
    else $error("stimulus pulse too short");
  a_normal_quiet: assert property (normal_mode |-> !selftest_stim_en && !offset_hold)
    else $error("self-test activity in normal mode");
  a_normal_msg_kinds: assert property (frame_strobe_q && normal_mode |->
    msg_kind_q inside {`ISTS_MSG_READY, `ISTS_MSG_DEFECT, `ISTS_MSG_DATA})
    else $error("init message in normal mode");
  a_strobe_has_kind: assert property (frame_strobe_q |-> msg_kind_q != `ISTS_MSG_NONE)
    else $error("frame sent without a kind");
  a_frame_period: assert property (frame_strobe_q && seen_q |-> gap_q % FRAME_CYCLES == 0)
    else $error("frame spacing off the frame period");
  a_uv_silent: assert property (uv_trip_pin [*4] |-> !frame_strobe_q)
    else $error("frame sent during undervoltage");
  a_integ_latched: assert property (frame_strobe_q && normal_mode && $past(bad_q, 3) |->
    msg_kind_q == `ISTS_MSG_DEFECT)
    else $error("integrity defect not reported");
endmodule // ists_props

/* File: test/ists_rx_model.sv */
// receiving end of the frame link: logs each message kind it takes
module ists_rx_model (
  input wire ref_clk,
  input wire resetn,
  input wire frame_strobe_q,
  input wire [2:0] msg_kind_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] kinds[$];

  // the kind is only meaningful on a strobe; a sensor reset restarts the log
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      kinds.delete();
    else if (frame_strobe_q)
      kinds.push_back(msg_kind_q);
  end
endmodule // ists_rx_model

/* File: test/tb.sv */
`include "ists_map.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [15:0] FRAME = 16'h0014;
  localparam int PRE_MS = 1018; // init plus both offset-cancel times
  localparam int TRY_MS = 18; // one pass: interval one, two, the hold and three
  logic ref_clk, resetn, reg_wr, reg_rd, sample_valid, uv_trip_pin;
  logic integrity_flag_a, integrity_flag_b, stim_prev;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, accel_sample, ofs_val, stim_val, rd;
  wire [15:0] reg_rdata, offset_est_q;
  wire selftest_stim_en, offset_hold, frame_strobe_q, normal_mode, irq;
  wire [2:0] msg_kind_q;
  int n_errors, n_compared, cyc, n_stim, n0;

  // short ms and frame counts keep one init sequence near 11k cycles
  // a long init delay pushes the self-test end into phase three, so busy frames show
  ists_sequencer #(.MS_CYCLES(16'h000A), .FRAME_CYCLES(FRAME), .INIT_MS(16'h03F0),
    .ST1_MS(16'h0004), .ST2_MS(16'h0008), .ST3_MS(16'h0004)) ists_sequencer_i (
    .ref_clk(ref_clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .accel_sample(accel_sample), .uv_trip_pin(uv_trip_pin),
    .integrity_flag_a(integrity_flag_a), .integrity_flag_b(integrity_flag_b),
    .selftest_stim_en(selftest_stim_en), .offset_hold(offset_hold),
    .offset_est_q(offset_est_q), .frame_strobe_q(frame_strobe_q),
    .msg_kind_q(msg_kind_q), .normal_mode(normal_mode), .irq(irq));
  ists_rx_model rx_i (.ref_clk(ref_clk), .resetn(resetn),
    .frame_strobe_q(frame_strobe_q), .msg_kind_q(msg_kind_q));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // sensor front end: noisy samples, deflected while the stimulus is on
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    sample_valid <= ~sample_valid;
    accel_sample <= (selftest_stim_en ? stim_val : ofs_val) + 16'($urandom % 4);
    stim_prev <= selftest_stim_en;
    if (selftest_stim_en && !stim_prev)
      n_stim <= n_stim + 1;
    if (cyc == 45000)
    begin
      n_errors++;
      finish_test();
    end
  end

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    rd = reg_rdata;
  endtask

  task start_run(input logic [2:0] retry, input logic [15:0] stim);
    resetn <= 1'b0;
    stim_val <= stim;
    ofs_val <= 16'h0010;
    n_stim <= 0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    wr(`ISTS_REG_CTRL, {13'h0000, retry});
    while (rx_i.kinds.size() < 552) @(posedge ref_clk);
  endtask

  function automatic logic [15:0] last_kind();
    return 16'(rx_i.kinds[rx_i.kinds.size() - 1]);
  endfunction

  // expected frame order: init1, init2, any busy, two results, then steady kind
  task check_seq(input logic [2:0] res, input int tries);
    int i;
    int busy;
    for (i = 0; i < 516; i++)
      chk("init_msg", 16'(rx_i.kinds[i]), (i < 4) ? 16'h0001 : 16'h0002);
    while (i < 600 && rx_i.kinds[i] === `ISTS_MSG_BUSY) i++;
    // a tick is busy while it falls on or before the 10-cycle ms tick that ends the test
    busy = (PRE_MS + tries * TRY_MS) / 2 - 516;
    chk("busy_count", 16'(i - 516), 16'(busy));
    chk("result_a", 16'(rx_i.kinds[i]), 16'(res));
    chk("result_b", 16'(rx_i.kinds[i + 1]), 16'(res));
    chk("after", 16'(rx_i.kinds[i + 2]), (res == `ISTS_MSG_READY) ? 16'h0006 : 16'h0005);
    chk("stim_runs", 16'(n_stim), 16'(tries));
  endtask

  initial
  begin
    void'($urandom(72));
    {resetn, reg_wr, reg_rd, sample_valid, uv_trip_pin, stim_prev} = '0;
    {integrity_flag_a, integrity_flag_b} = 2'b11;
    {reg_addr, reg_wdata, accel_sample, ofs_val, stim_val} = '0;
    {n_errors, n_compared, cyc, n_stim} = '0;
    start_run(3'h2, 16'h0210);
    check_seq(`ISTS_MSG_READY, 1);
    rd_reg(`ISTS_REG_DEFL_HI);
    chk("defl_hi", rd, 16'h0400);
    rd_reg(`ISTS_REG_DEFL_LO);
    chk("defl_lo", rd, 16'h0100);
    rd_reg(`ISTS_REG_OFS_LIM);
    chk("ofs_lim", rd, 16'h0200);
    rd_reg(8'h3C);
    chk("unmapped", rd, 16'h0000);
    rd_reg(`ISTS_REG_STATUS);
    chk("status_pass", rd & 16'h07F8, 16'h0618);
    chk("normal", 16'(normal_mode), 16'h0001);
    rd_reg(`ISTS_REG_OFFSET);
    chk("offset_est", rd & 16'hFFFC, 16'h0010);
    rd_reg(`ISTS_REG_IRQ_STAT);
    chk("irq_pass", rd, 16'h0001);
    chk("irq_masked", 16'(irq), 16'h0000);
    wr(`ISTS_REG_IRQ_MASK, 16'h001F);
    @(posedge ref_clk);
    chk("irq_on", 16'(irq), 16'h0001);
    wr(`ISTS_REG_IRQ_STAT, 16'h0001);
    @(posedge ref_clk);
    chk("irq_clear", 16'(irq), 16'h0000);
    // offset error is temporary and tracked window by window
    ofs_val <= 16'h0300;
    repeat (200) @(posedge ref_clk);
    chk("ofs_err", last_kind(), 16'h0005);
    chk("ofs_irq", 16'(irq), 16'h0001);
    ofs_val <= 16'h0010;
    wr(`ISTS_REG_IRQ_STAT, 16'h001F);
    repeat (200) @(posedge ref_clk);
    chk("ofs_back", last_kind(), 16'h0006);
    // undervoltage silences the link, then it recovers without reset
    uv_trip_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    n0 = rx_i.kinds.size();
    repeat (200) @(posedge ref_clk);
    chk("uv_silent", 16'(rx_i.kinds.size() - n0), 16'h0000);
    rd_reg(`ISTS_REG_STATUS);
    chk("uv_status", rd & 16'h0100, 16'h0100);
    uv_trip_pin <= 1'b0;
    repeat (200) @(posedge ref_clk);
    chk("uv_back", 16'(rx_i.kinds.size() > n0 + 5), 16'h0001);
    chk("uv_kind", last_kind(), 16'h0006);
    // a short integrity drop latches a defect
    integrity_flag_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    integrity_flag_b <= 1'b1;
    repeat (200) @(posedge ref_clk);
    chk("integ", last_kind(), 16'h0005);
    rd_reg(`ISTS_REG_STATUS);
    chk("integ_status", rd & 16'h0040, 16'h0040);
    // deflection below the lower limit, three retries, all failing
    start_run(3'h3, 16'h0010);
    check_seq(`ISTS_MSG_DEFECT, 4);
    rd_reg(`ISTS_REG_STATUS);
    chk("status_fail", rd & 16'h07F0, 16'h0620);
    rd_reg(`ISTS_REG_IRQ_STAT);
    chk("irq_fail", rd & 16'h0003, 16'h0002);
    repeat (300) @(posedge ref_clk);
    chk("still_defect", last_kind(), 16'h0005);
    // deflection above the upper limit with no retry at all
    start_run(3'h0, 16'h0510);
    check_seq(`ISTS_MSG_DEFECT, 1);
    finish_test();
  end
endmodule // tb

bind ists_sequencer ists_props #(.MS_CYCLES(MS_CYCLES), .FRAME_CYCLES(FRAME_CYCLES)) props_i (
  .ref_clk(ref_clk), .resetn(resetn), .uv_trip_pin(uv_trip_pin),
  .integrity_flag_a(integrity_flag_a), .integrity_flag_b(integrity_flag_b),
  .selftest_stim_en(selftest_stim_en), .offset_hold(offset_hold),
  .offset_est_q(offset_est_q), .frame_strobe_q(frame_strobe_q),
  .msg_kind_q(msg_kind_q), .normal_mode(normal_mode));
